/* src/nbi_pkg.sv */
// Contract
// - upper lines carry data only, never command/address
// - host waits 10 us after power-up, strobe high
// - host holds protect low during power transitions
// - host treats shared busy low as someone busy
// - command: select low, command high, address low, read high
// - host sends four or five address cycles by density
// - address: select low, address high, command low, read high
package nbi_pkg;
  // clock and timing
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned CLK_NS = 1000 / CLK_MHZ;
  localparam int unsigned T_PWRUP_US = 10; // least recovery time
  localparam int unsigned PWRUP_CYC = T_PWRUP_US * CLK_MHZ;
  localparam int unsigned T_GUARD_NS = 200; // busy line may lag the last strobe
  localparam int unsigned GUARD_CYC = (T_GUARD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RD_SAMPLE_CYC = 3; // read strobe low, covers the 2-flop sync
  // array geometry of the device outside
  localparam int unsigned PAGES_PER_BLOCK = 64;
  localparam int unsigned MAIN_BYTES = 2048;
  localparam int unsigned SPARE_BYTES = 64;
  localparam int unsigned MAIN_WORDS = 1024;
  localparam int unsigned SPARE_WORDS = 32;
  localparam int unsigned BLOCKS_1G = 1024;
  localparam int unsigned MIN_BLOCKS_1G = 1004;
  localparam int unsigned BLOCKS_2G = 2048;
  localparam int unsigned MIN_BLOCKS_2G = 2008;
  localparam int unsigned ADDR_CYC_1G = 4;
  localparam int unsigned ADDR_CYC_2G = 5;
  // address field and bus widths
  localparam int unsigned COL_W = 12;
  localparam int unsigned ROW_W = 17;
  localparam int unsigned IO_W = 16;
  // user operations
  typedef enum logic [2:0] {
    NBI_OP_CMD = 3'h0,
    NBI_OP_ADDR = 3'h1,
    NBI_OP_WRITE = 3'h2,
    NBI_OP_READ = 3'h3,
    NBI_OP_WAIT = 3'h4
  } nbi_op_t;
  // controller states, gray along power, idle, strobe, hold
  typedef enum logic [2:0] {
    NBI_ST_POWER = 3'h0,
    NBI_ST_IDLE = 3'h1,
    NBI_ST_WSTROBE = 3'h3,
    NBI_ST_WHOLD = 3'h2,
    NBI_ST_RLOW = 3'h6,
    NBI_ST_RHIGH = 3'h7,
    NBI_ST_WAIT = 3'h5
  } nbi_state_t;

  // byte of an address cycle; col then row, top cycle holds one bit
  function automatic logic [7:0] nbi_addr_byte(input logic [COL_W-1:0] col,
                                               input logic [ROW_W-1:0] row,
                                               input logic [2:0] idx);
    case (idx)
      3'h0: nbi_addr_byte = col[7:0];
      3'h1: nbi_addr_byte = {4'h0, col[11:8]};
      3'h2: nbi_addr_byte = row[7:0];
      3'h3: nbi_addr_byte = row[15:8];
      default: nbi_addr_byte = {7'h00, row[16]};
    endcase
  endfunction : nbi_addr_byte
endpackage : nbi_pkg

/* src/nbi_skid2.sv */
`timescale 1ns/1ps
// two-entry buffer; head entry drives the output straight from flops
module nbi_skid2 #(
  parameter int unsigned W = 16 // word width
) (
  input wire logic sys_clk, // system clock
  input wire logic reset, // sync, active high
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [W-1:0] in_data, // offered word
  output logic out_valid, // head word valid
  input wire logic out_ready, // consumer takes head
  output logic [W-1:0] out_data // head word
);
  logic head_v_reg; // head occupied
  logic tail_v_reg; // tail occupied
  logic [W-1:0] head_reg; // head word
  logic [W-1:0] tail_reg; // tail word
  logic push; // word enters
  logic pop; // word leaves

  // full only when the tail is taken, so a stall still catches one word
  assign in_ready = ~tail_v_reg;
  assign push = in_valid & in_ready;
  assign pop = head_v_reg & out_ready;
  assign out_valid = head_v_reg;
  assign out_data = head_reg;

  // occupancy and data movement
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
      head_reg <= '0;
      tail_reg <= '0;
    end else if (pop) begin
      // tail moves forward, or a fresh word falls straight in
      head_v_reg <= tail_v_reg | push;
      head_reg <= tail_v_reg ? tail_reg : in_data;
      tail_v_reg <= 1'b0;
    end else if (push) begin
      if (!head_v_reg) begin
        head_v_reg <= 1'b1;
        head_reg <= in_data;
      end else begin
        tail_v_reg <= 1'b1;
        tail_reg <= in_data;
      end
    end
  end
endmodule : nbi_skid2

/* src/nbi_host.sv */
`timescale 1ns/1ps
// host side strobe engine for a page flash on a multiplexed bus
module nbi_host #(
  parameter bit BUS16 = 1'b0, // word-wide device attached
  parameter bit DENSITY_2G = 1'b0 // larger density, five address cycles
) (
  input wire logic sys_clk, // 10 MHz system clock
  input wire logic reset, // sync, active high
  input wire logic cmd_valid, // operation offered
  output logic cmd_ready, // engine idle, takes an operation
  input wire nbi_pkg::nbi_op_t cmd_op, // operation kind
  input wire logic [15:0] cmd_data, // command byte or write word
  input wire logic [nbi_pkg::COL_W-1:0] cmd_col, // column for address op
  input wire logic [nbi_pkg::ROW_W-1:0] cmd_row, // page and block for address op
  input wire logic prog_enable, // allow program and erase
  output logic rd_valid, // read word available
  input wire logic rd_ready, // consumer takes read word
  output logic [15:0] rd_data, // read word
  output logic ce_n, // chip select, active low
  output logic command_qualifier, // marks command cycles
  output logic address_qualifier, // marks address cycles
  output logic we_n, // write strobe, active low
  output logic re_n, // read strobe, active low
  output logic wp_n, // write protect, active low
  output logic [15:0] io_out, // bus value driven
  output logic io_oe, // high while host drives the bus
  input wire logic [15:0] io_in, // bus value seen
  input wire logic busy_flag_n // shared busy line, low while busy
);
  import nbi_pkg::*;

  localparam int unsigned ADDR_CYC = DENSITY_2G ? ADDR_CYC_2G : ADDR_CYC_1G;
  localparam int unsigned PW = $clog2(PWRUP_CYC + 1);

  nbi_state_t state_reg; // engine state
  nbi_op_t op_reg; // operation in progress
  logic [PW-1:0] pwr_cnt_reg; // power-up recovery countdown
  logic [1:0] guard_cnt_reg; // guard before trusting busy line
  logic [1:0] rd_cnt_reg; // read strobe low time
  logic [2:0] addr_idx_reg; // address cycle index
  logic [COL_W-1:0] col_reg; // latched column
  logic [ROW_W-1:0] row_reg; // latched row
  logic busy_meta_reg; // busy sync stage 1
  logic busy_sync_reg; // busy sync stage 2
  logic [15:0] io_meta_reg; // bus sync stage 1
  logic [15:0] io_sync_reg; // bus sync stage 2
  logic ce_n_reg, cle_reg, ale_reg, we_n_reg, re_n_reg, wp_n_reg; // pin flops
  logic [15:0] io_out_reg; // driven bus value
  logic io_oe_reg; // bus drive enable
  logic cmd_ready_reg; // idle and accepting
  logic take; // operation accepted
  logic buf_in_valid; // read word captured
  logic buf_in_ready; // buffer has room
  logic [15:0] buf_in_data; // captured word

  assign take = cmd_valid & cmd_ready_reg;
  assign cmd_ready = cmd_ready_reg;
  assign ce_n = ce_n_reg;
  assign command_qualifier = cle_reg;
  assign address_qualifier = ale_reg;
  assign we_n = we_n_reg;
  assign re_n = re_n_reg;
  assign wp_n = wp_n_reg;
  assign io_out = io_out_reg;
  assign io_oe = io_oe_reg;

  // pins from the far side pass two flops before use
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy_meta_reg <= 1'b0;
      busy_sync_reg <= 1'b0;
      io_meta_reg <= 16'h0000;
      io_sync_reg <= 16'h0000;
    end else begin
      busy_meta_reg <= busy_flag_n;
      busy_sync_reg <= busy_meta_reg;
      io_meta_reg <= io_in;
      io_sync_reg <= io_meta_reg;
    end
  end

  // recovery countdown after reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pwr_cnt_reg <= PW'(PWRUP_CYC);
    end else if (pwr_cnt_reg != '0) begin
      pwr_cnt_reg <= pwr_cnt_reg - 1'b1;
    end
  end

  // protect stays low until recovery is over, then follows software
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wp_n_reg <= 1'b0;
    end else begin
      wp_n_reg <= (state_reg != NBI_ST_POWER) & prog_enable;
    end
  end

  // x8 parts leave the upper lines floating; mask them off
  assign buf_in_data = BUS16 ? io_sync_reg : {8'h00, io_sync_reg[7:0]};
  assign buf_in_valid = (state_reg == NBI_ST_RLOW) && (rd_cnt_reg == 2'h0);

  // main sequencer: drives every strobe, qualifier and the bus
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= NBI_ST_POWER;
      op_reg <= NBI_OP_CMD;
      guard_cnt_reg <= 2'h0;
      rd_cnt_reg <= 2'h0;
      addr_idx_reg <= 3'h0;
      col_reg <= '0;
      row_reg <= '0;
      ce_n_reg <= 1'b1;
      cle_reg <= 1'b0;
      ale_reg <= 1'b0;
      we_n_reg <= 1'b1;
      re_n_reg <= 1'b1;
      io_out_reg <= 16'h0000;
      io_oe_reg <= 1'b0;
      cmd_ready_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        NBI_ST_POWER: begin
          // write strobe held high, no command before recovery ends
          if (pwr_cnt_reg == '0) begin
            state_reg <= NBI_ST_IDLE;
            ce_n_reg <= 1'b0; // single device, kept selected
            cmd_ready_reg <= 1'b1;
          end
        end
        NBI_ST_IDLE: begin
          if (take) begin
            cmd_ready_reg <= 1'b0;
            op_reg <= cmd_op;
            col_reg <= cmd_col;
            row_reg <= cmd_row;
            addr_idx_reg <= 3'h0;
            unique case (cmd_op)
              NBI_OP_CMD: begin
                // command on low lines, address qualifier low
                cle_reg <= 1'b1;
                io_out_reg <= {8'h00, cmd_data[7:0]};
                io_oe_reg <= 1'b1;
                we_n_reg <= 1'b0;
                state_reg <= NBI_ST_WSTROBE;
              end
              NBI_OP_ADDR: begin
                ale_reg <= 1'b1;
                io_out_reg <= {8'h00, nbi_addr_byte(cmd_col, cmd_row, 3'h0)};
                io_oe_reg <= 1'b1;
                we_n_reg <= 1'b0;
                state_reg <= NBI_ST_WSTROBE;
              end
              NBI_OP_WRITE: begin
                io_out_reg <= BUS16 ? cmd_data : {8'h00, cmd_data[7:0]};
                io_oe_reg <= 1'b1;
                we_n_reg <= 1'b0;
                state_reg <= NBI_ST_WSTROBE;
              end
              NBI_OP_READ: begin
                re_n_reg <= 1'b0;
                rd_cnt_reg <= 2'(RD_SAMPLE_CYC - 1);
                state_reg <= NBI_ST_RLOW;
              end
              default: begin
                // wait op; unknown codes also fall here, harmlessly
                guard_cnt_reg <= 2'(GUARD_CYC);
                state_reg <= NBI_ST_WAIT;
              end
            endcase
          end
        end
        NBI_ST_WSTROBE: begin
          we_n_reg <= 1'b1; // rising edge latches the bus
          state_reg <= NBI_ST_WHOLD;
        end
        NBI_ST_WHOLD: begin
          // address op repeats until the density's cycle count is sent
          if (op_reg == NBI_OP_ADDR && 32'(addr_idx_reg) + 1 < ADDR_CYC) begin
            addr_idx_reg <= addr_idx_reg + 3'h1;
            io_out_reg <= {8'h00, nbi_addr_byte(col_reg, row_reg, addr_idx_reg + 3'h1)};
            we_n_reg <= 1'b0;
            state_reg <= NBI_ST_WSTROBE;
          end else begin
            cle_reg <= 1'b0;
            ale_reg <= 1'b0;
            io_oe_reg <= 1'b0;
            cmd_ready_reg <= 1'b1;
            state_reg <= NBI_ST_IDLE;
          end
        end
        NBI_ST_RLOW: begin
          // a full buffer stretches the strobe; no word is lost
          if (rd_cnt_reg != 2'h0) begin
            rd_cnt_reg <= rd_cnt_reg - 2'h1;
          end else if (buf_in_ready) begin
            re_n_reg <= 1'b1;
            state_reg <= NBI_ST_RHIGH;
          end
        end
        NBI_ST_RHIGH: begin
          cmd_ready_reg <= 1'b1;
          state_reg <= NBI_ST_IDLE;
        end
        NBI_ST_WAIT: begin
          // shared line: low means at least one part still busy
          if (guard_cnt_reg != 2'h0) begin
            guard_cnt_reg <= guard_cnt_reg - 2'h1;
          end else if (busy_sync_reg) begin
            cmd_ready_reg <= 1'b1;
            state_reg <= NBI_ST_IDLE;
          end
        end
        default: begin
          state_reg <= NBI_ST_IDLE;
          cmd_ready_reg <= 1'b1;
        end
      endcase
    end
  end

  // read words queue here; head flops drive rd_valid and rd_data
  nbi_skid2 #(.W(IO_W)) u_rd_buf (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // helper: address strobes since the last accepted operation
  logic [2:0] addr_rise_cnt_reg;
  always_ff @(posedge sys_clk) begin
    if (reset || take) begin
      addr_rise_cnt_reg <= 3'h0;
    end else if (state_reg == NBI_ST_WSTROBE && ale_reg) begin
      addr_rise_cnt_reg <= addr_rise_cnt_reg + 3'h1;
    end
  end

  property p_pwr_quiet;
    @(posedge sys_clk) disable iff (reset)
      (pwr_cnt_reg != '0) |-> we_n_reg && cmd_ready_reg == 1'b0;
  endproperty
  a_pwr_quiet: assert property (p_pwr_quiet) else $error("strobe or ready during recovery");

  property p_pwr_len;
    @(posedge sys_clk) disable iff (reset)
      $rose(cmd_ready_reg) && $past(state_reg) == NBI_ST_POWER |-> $past(pwr_cnt_reg) == '0;
  endproperty
  a_pwr_len: assert property (p_pwr_len) else $error("recovery ended early");

  property p_wp_low;
    @(posedge sys_clk) disable iff (reset)
      (state_reg == NBI_ST_POWER) |=> !wp_n_reg;
  endproperty
  a_wp_low: assert property (p_wp_low) else $error("protect released during recovery");

  property p_cmd_cycle;
    @(posedge sys_clk) disable iff (reset)
      $fell(we_n_reg) && cle_reg |-> (!ce_n_reg && !ale_reg && re_n_reg)
        ##1 ($rose(we_n_reg) && cle_reg);
  endproperty
  a_cmd_cycle: assert property (p_cmd_cycle) else $error("bad command cycle");

  property p_addr_cycle;
    @(posedge sys_clk) disable iff (reset)
      $fell(we_n_reg) && ale_reg |-> (!ce_n_reg && !cle_reg && re_n_reg)
        ##1 ($rose(we_n_reg) && ale_reg);
  endproperty
  a_addr_cycle: assert property (p_addr_cycle) else $error("bad address cycle");

  property p_addr_count;
    @(posedge sys_clk) disable iff (reset)
      $fell(ale_reg) |-> addr_rise_cnt_reg == 3'(ADDR_CYC);
  endproperty
  a_addr_count: assert property (p_addr_count) else $error("wrong address cycle count");

  property p_low_lines;
    @(posedge sys_clk) disable iff (reset)
      io_oe_reg && (cle_reg || ale_reg) |-> io_out_reg[15:8] == 8'h00;
  endproperty
  a_low_lines: assert property (p_low_lines) else $error("upper lines used for cmd/addr");

  property p_busy_hold;
    @(posedge sys_clk) disable iff (reset)
      state_reg == NBI_ST_WAIT && !busy_sync_reg |=> state_reg == NBI_ST_WAIT;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("left wait while busy");

  property p_read_quals;
    @(posedge sys_clk) disable iff (reset)
      !re_n_reg |-> we_n_reg && !cle_reg && !ale_reg && !io_oe_reg;
  endproperty
  a_read_quals: assert property (p_read_quals) else $error("read strobe with bad qualifiers");

  c_addr_seq: cover property (@(posedge sys_clk) disable iff (reset) $fell(ale_reg));
  c_read_word: cover property (@(posedge sys_clk) disable iff (reset) buf_in_valid && buf_in_ready);
  c_read_stall: cover property (@(posedge sys_clk) disable iff (reset) buf_in_valid && !buf_in_ready);
  c_wait_done: cover property (@(posedge sys_clk) disable iff (reset)
    state_reg == NBI_ST_WAIT ##1 state_reg == NBI_ST_IDLE);
endmodule : nbi_host

/* testbench/nbi_flash_model.sv */
`timescale 1ns/1ps
// behavioural flash device on the far side of the strobe engine
module nbi_flash_model
  import nbi_pkg::*;
#(
  parameter bit BUS16 = 1'b0, // word-wide part
  parameter bit DENSITY_2G = 1'b0, // five address cycles
  parameter logic [7:0] BUSY_CMD = 8'h30, // opcode that starts an internal read
  parameter int BUSY_NS = 2000, // internal operation time
  parameter int ACC_NS = 20 // read strobe fall to data
) (
  input wire logic ce_n, // chip select
  input wire logic command_qualifier, // command cycle
  input wire logic address_qualifier, // address cycle
  input wire logic we_n, // write strobe
  input wire logic re_n, // read strobe
  input wire logic wp_n, // write protect
  input wire logic [15:0] io, // resolved bus
  output logic [15:0] dev_io, // what the device puts out
  output logic busy_flag_n, // open drain, pulled up
  output logic [7:0] last_cmd, // last command byte
  output logic [39:0] addr_bytes, // address cycles, first in low byte
  output logic [3:0] addr_cnt, // address cycles seen
  output logic [11:0] col_ctr, // column counter
  output logic [7:0] rej_cnt, // refused data words
  output logic hi_seen // upper lines used for command or address
);
  localparam int NCYC = DENSITY_2G ? ADDR_CYC_2G : ADDR_CYC_1G; // cycles the density needs
  logic [15:0] mem [0:MAIN_BYTES+SPARE_BYTES-1]; // one page, main then spare
  logic [15:0] dout; // read value
  logic drive; // read data on the bus
  logic busy; // internal operation running
  realtime t_fall; // last write strobe fall
  // a busy part stays selected even with select high
  wire sel = !ce_n || busy;
  // released bus shows the inverse of the last value, so a stale word cannot pass
  assign dev_io = drive ? {BUS16 ? dout[15:8] : 8'hFF, dout[7:0]} : ~dout;
  assign busy_flag_n = !busy;
  initial begin
    dout = 16'h0000;
    drive = 1'b0;
    busy = 1'b0;
    last_cmd = 8'h00;
    addr_bytes = 40'h00_0000_0000;
    addr_cnt = 4'h0;
    col_ctr = 12'h000;
    rej_cnt = 8'h00;
    hi_seen = 1'b0;
    t_fall = 0.0;
  end
  always @(negedge we_n) t_fall = $realtime;
  // inputs taken on the strobe rise; pulses under 5 ns are glitches
  always @(posedge we_n) begin
    if (sel && re_n && ($realtime - t_fall >= 5.0)) begin
      if (command_qualifier && !address_qualifier) begin
        last_cmd = io[7:0];
        hi_seen = hi_seen | (io[15:8] != 8'h00);
        addr_cnt = 4'h0;
        busy = (io[7:0] == BUSY_CMD);
        if (busy) busy <= #(BUSY_NS) 1'b0;
      end else if (address_qualifier && !command_qualifier) begin
        hi_seen = hi_seen | (io[15:8] != 8'h00);
        // surplus cycles are dropped
        if (addr_cnt < NCYC) addr_bytes[{addr_cnt, 3'b000} +: 8] = io[7:0];
        addr_cnt = addr_cnt + 4'h1;
        if (addr_cnt == 4'h2) col_ctr = {addr_bytes[11:8], addr_bytes[7:0]};
      end else if (!address_qualifier && !command_qualifier) begin
        if (!wp_n) begin // protect low, word refused
          rej_cnt = rej_cnt + 8'h01;
        end else begin
          mem[col_ctr] = BUS16 ? io : {8'h00, io[7:0]};
          col_ctr = col_ctr + 12'h001;
        end
      end
    end
  end
  // each read strobe fall puts out the next column
  always @(negedge re_n) begin
    if (sel && we_n && !command_qualifier && !address_qualifier) begin
      dout <= #(ACC_NS) mem[col_ctr];
      drive <= #(ACC_NS) 1'b1;
      col_ctr = col_ctr + 12'h001;
    end
  end
  // bus let go shortly after the strobe rises or select drops
  always @(posedge re_n or posedge ce_n) drive <= #(10) 1'b0;
endmodule : nbi_flash_model

/* testbench/nbi_host_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module nbi_host_bench;
  import nbi_pkg::*;
  localparam int BUSY_CYC = 20; // model busy time in clocks
  logic sys_clk, reset, cmd_valid, cmd_ready, prog_enable, rd_valid, rd_ready;
  nbi_op_t cmd_op; // operation kind
  logic [15:0] cmd_data, rd_data, io_out, io_in, dev_io; // data paths
  logic [COL_W-1:0] cmd_col; // column
  logic [ROW_W-1:0] cmd_row; // page and block
  logic ce_n, command_qualifier, address_qualifier, we_n, re_n, wp_n, io_oe, busy_flag_n;
  logic [7:0] m_cmd, m_rej; // model view
  logic [39:0] m_addr; // model address bytes
  logic [3:0] m_cnt; // model address count
  logic [11:0] m_col; // model column counter
  logic m_hi; // model saw upper lines
  int tests_run, miscompares, cyc, tot;
  nbi_host #(.BUS16(1'b0), .DENSITY_2G(1'b1)) uut (.sys_clk, .reset, .cmd_valid, .cmd_ready,
    .cmd_op, .cmd_data, .cmd_col, .cmd_row, .prog_enable, .rd_valid, .rd_ready, .rd_data,
    .ce_n, .command_qualifier, .address_qualifier, .we_n, .re_n, .wp_n, .io_out, .io_oe,
    .io_in, .busy_flag_n);
  // host owns the bus while enabled, the device otherwise
  assign io_in = io_oe ? io_out : dev_io;
  nbi_flash_model #(.BUS16(1'b0), .DENSITY_2G(1'b1), .BUSY_NS(BUSY_CYC * CLK_NS)) dev (
    .ce_n, .command_qualifier, .address_qualifier, .we_n, .re_n, .wp_n, .io(io_in),
    .dev_io, .busy_flag_n, .last_cmd(m_cmd), .addr_bytes(m_addr), .addr_cnt(m_cnt),
    .col_ctr(m_col), .rej_cnt(m_rej), .hi_seen(m_hi));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // counts, verdict, end of run
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // edges until cmd_ready is sampled high; running out ends the run
  task automatic wait_ready(input int limit, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > limit) begin
        miscompares++;
        $display("Error at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
        summarize();
      end
    end while (cmd_ready !== 1'b1);
  endtask : wait_ready
  // one operation; n is edges from take until idle is seen again
  task automatic run_op(input nbi_op_t op, input logic [15:0] d, output int n);
    int t;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    wait_ready(200, t);
    cmd_valid <= 1'b0;
    @(posedge sys_clk);
    wait_ready(400, n);
    n++;
  endtask : run_op
  // reset, then the recovery wait with quiet pins
  task automatic reset_check;
    int n;
    repeat (6) @(posedge sys_clk);
    `CHK({ce_n, we_n, re_n, wp_n, io_oe}, 5'b11100)
    reset <= 1'b0;
    repeat (50) @(posedge sys_clk);
    `CHK({ce_n, we_n, wp_n, cmd_ready}, 4'b1100)
    wait_ready(200, n);
    `CHK(n + 50 >= PWRUP_CYC, 1'b1)
  endtask : reset_check
  // command byte with junk on the upper half; ready seen one edge after it rises
  task automatic cmd_check;
    run_op(NBI_OP_CMD, 16'hFF80, cyc);
    `CHK(cyc, 3)
    `CHK({m_cmd, m_hi}, {8'h80, 1'b0})
  endtask : cmd_check
  // five address cycles, column first
  task automatic addr_check;
    run_op(NBI_OP_ADDR, 16'h0000, cyc);
    `CHK(cyc, 2 * ADDR_CYC_2G + 1)
    `CHK({m_cnt, m_addr}, {4'h5, 40'h01_2C3D_07A5})
    `CHK({m_hi, m_col}, {1'b0, 12'h7A5})
    // row splits into 64 pages per block; block index stays inside the array
    `CHK({m_addr[32:22] < BLOCKS_2G, m_addr[21:16]}, {1'b1, 6'h3D})
  endtask : addr_check
  // refused word under protect, then two accepted words
  task automatic write_check;
    run_op(NBI_OP_WRITE, 16'h005A, cyc);
    `CHK({m_rej, m_col}, {8'h01, 12'h7A5})
    prog_enable <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK(wp_n, 1'b1)
    run_op(NBI_OP_WRITE, 16'h005A, cyc);
    run_op(NBI_OP_WRITE, 16'h00C3, cyc);
    `CHK({m_rej, m_col}, {8'h01, 12'h7A7})
  endtask : write_check
  // two reads into a stalled buffer, then drain in order
  task automatic read_check;
    int k;
    // a command first, so the part takes the address cycles afresh
    run_op(NBI_OP_CMD, 16'h0000, cyc);
    run_op(NBI_OP_ADDR, 16'h0000, cyc);
    run_op(NBI_OP_READ, 16'h0000, cyc);
    run_op(NBI_OP_READ, 16'h0000, cyc);
    `CHK({rd_valid, m_col}, {1'b1, 12'h7A7})
    rd_ready <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      k = 0;
      do begin
        @(posedge sys_clk);
        k++;
      end while (rd_valid !== 1'b1 && k < 20);
      if (k >= 20) begin
        miscompares++;
        $display("Error at %0t: read wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
        summarize();
      end
      `CHK(rd_data, (i == 0) ? 16'h005A : 16'h00C3)
    end
    rd_ready <= 1'b0;
    @(posedge sys_clk);
    `CHK(rd_valid, 1'b0)
  endtask : read_check
  // device busy after a command; wait op must outlast it
  task automatic busy_check;
    run_op(NBI_OP_CMD, 16'h0030, cyc);
    `CHK(busy_flag_n, 1'b0)
    tot = cyc;
    run_op(NBI_OP_WAIT, 16'h0000, cyc);
    tot = tot + cyc;
    `CHK(tot >= BUSY_CYC, 1'b1)
    `CHK(tot <= BUSY_CYC + 12, 1'b1)
    `CHK(busy_flag_n, 1'b1)
  endtask : busy_check
  initial begin
    tests_run = 0;
    miscompares = 0;
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = NBI_OP_WAIT;
    cmd_data = 16'h0000;
    cmd_col = 12'h7A5;
    cmd_row = 17'h1_2C3D;
    prog_enable = 1'b0;
    rd_ready = 1'b0;
    reset_check();
    cmd_check();
    addr_check();
    write_check();
    read_check();
    busy_check();
    summarize();
  end
endmodule : nbi_host_bench
